/* rtl/gpiop_top.sv */
// GPIO ports with AXI4-Lite registers, pin and group interrupts
// Port p words sit at p * 0x40; global words start at 0x200.
// Port words: out, set, clr, dir, msk, pin, mpin, ien, puen, fsel, ga, gb.
// Global words: eight source selects, sticky status, interrupt mask.
// Source select: pin [4:0], port [7:5], level [8], active high [9].
//
// Local design decisions: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module gpiop_top
   import gpiop_pkg::*;
(
   // Clock and reset
   input  wire logic          clk,
   input  wire logic          resetn,
   // AXI4-Lite write address and data
   input  wire logic          s_axi_awvalid,
   output var  logic          s_axi_awready,
   input  wire logic [AW-1:0] s_axi_awaddr,
   input  wire logic          s_axi_wvalid,
   output var  logic          s_axi_wready,
   input  wire logic [31:0]   s_axi_wdata,
   input  wire logic [3:0]    s_axi_wstrb,
   // AXI4-Lite write response
   output var  logic          s_axi_bvalid,
   input  wire logic          s_axi_bready,
   output var  logic [1:0]    s_axi_bresp,
   // AXI4-Lite read
   input  wire logic          s_axi_arvalid,
   output var  logic          s_axi_arready,
   input  wire logic [AW-1:0] s_axi_araddr,
   output var  logic          s_axi_rvalid,
   input  wire logic          s_axi_rready,
   output var  logic [31:0]   s_axi_rdata,
   output var  logic [1:0]    s_axi_rresp,
   // Pads
   input  wire gpiop_bank_t   pad_in,
   output var  gpiop_pad_t    pad,
   // Interrupts
   output var  logic          irq,
   output var  logic          pin_group_irq_a,
   output var  logic          pin_group_irq_b
);

   gpiop_state_t    r;
   gpiop_state_t    n;
   gpiop_bank_t     live;
   logic [31:0]     lm;
   logic [NPIN-1:0] d;
   logic [2:0]      wp;
   logic [3:0]      wi;
   logic [9:0]      clr_st;
   logic [9:0]      set_st;
   logic            wr;
   logic            sv;
   logic            gcond_a;
   logic            gcond_b;

   // Lane mask from write strobes
   function automatic logic [31:0] lanes(input logic [3:0] s);
      lanes = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
   endfunction : lanes

   // Merge new bits into old under a bit mask
   function automatic logic [NPIN-1:0] merge(input logic [NPIN-1:0] o,
                                             input logic [NPIN-1:0] v,
                                             input logic [NPIN-1:0] m);
      merge = (o & ~m) | (v & m);
   endfunction : merge

   // Same merge for the ten-bit global words
   function automatic logic [9:0] merge10(input logic [9:0] o,
                                          input logic [9:0] v,
                                          input logic [9:0] m);
      merge10 = (o & ~m) | (v & m);
   endfunction : merge10

   // Active level of one interrupt source; pins past 30 read as low, so they fire only when active low
   function automatic logic src_level(input gpiop_bank_t lv,
                                      input logic [9:0]  s);
      logic [2:0] p;
      logic [4:0] b;
      logic       v;
      p         = s[SEL_PORT_LSB +: 3];
      b         = s[SEL_PIN_LSB +: 5];
      v         = (b < 5'(NPIN)) ? lv[p][b] : 1'b0;
      src_level = s[SEL_POL] ? v : ~v;
   endfunction : src_level

   // Address is mapped
   function automatic logic mapped(input logic [AW-1:0] a);
      if (a[11:10] != 2'h0) begin
         mapped = 1'b0;
      end else if (a[9]) begin
         mapped = (a[8:6] == 3'h0) && (a[5:2] <= IX_GMAX);
      end else begin
         mapped = a[5:2] <= IX_PMAX;
      end
   endfunction : mapped

   // Read data for one address
   function automatic logic [31:0] rd(input gpiop_state_t s,
                                      input gpiop_bank_t  lv,
                                      input logic [AW-1:0] a);
      logic [2:0] p;
      logic [3:0] i;
      p  = a[8:6];
      i  = a[5:2];
      rd = 32'h0;
      if (!mapped(a)) begin
         rd = 32'h0;
      end else if (a[9]) begin
         if (i < IX_STAT) begin
            rd = {22'h0, s.sel[i[2:0]]};
         end else if (i == IX_STAT) begin
            rd = {22'h0, s.stat};
         end else begin
            rd = {22'h0, s.imsk};
         end
      end else begin
         unique case (i)
            IX_OUT:  rd = {1'b0, s.out[p]};
            IX_DIR:  rd = {1'b0, s.dir[p]};
            IX_MSK:  rd = {1'b0, s.msk[p]};
            IX_PIN:  rd = {1'b0, lv[p]};
            IX_MPIN: rd = {1'b0, lv[p] & ~s.msk[p]};
            IX_IEN:  rd = {1'b0, s.ien[p]};
            IX_PUEN: rd = {1'b0, s.puen[p]};
            IX_FSEL: rd = {1'b0, s.fsel[p]};
            IX_GA:   rd = {1'b0, s.ga[p]};
            IX_GB:   rd = {1'b0, s.gb[p]};
            default: rd = 32'h0;                     // Set and clear
         endcase
      end
   endfunction : rd

   // Next state
   always_comb begin
      n       = r;
      // Pin inputs pass two flops; receiver enable gates them
      // A pin with its receiver off reads as zero
      n.sync1 = pad_in;
      n.sync2 = r.sync1;
      live    = r.sync2 & r.ien;

      // Address and data are taken in either order
      if (s_axi_awvalid && r.awready) begin
         n.awv = 1'b1;
         n.awa = s_axi_awaddr;
      end
      if (s_axi_wvalid && r.wready) begin
         n.wv = 1'b1;
         n.wd = s_axi_wdata;
         n.ws = s_axi_wstrb;
      end
      if (r.bvalid && s_axi_bready) begin
         n.bvalid = 1'b0;
      end

      // Register write, one cycle after both halves are held
      // A response still waiting holds the next write back
      wr     = r.awv && r.wv && !r.bvalid;
      lm     = lanes(r.ws);
      d      = r.wd[NPIN-1:0];
      wp     = r.awa[8:6];
      wi     = r.awa[5:2];
      clr_st = 10'h0;
      if (wr) begin
         n.awv    = 1'b0;
         n.wv     = 1'b0;
         n.bvalid = 1'b1;
         n.bresp  = mapped(r.awa) ? RESP_OKAY : RESP_DECERR;
         if (!mapped(r.awa)) begin
            n.bresp = RESP_DECERR;
         end else if (r.awa[9]) begin
            // Global words: source selects, status clear, mask
            if (wi < IX_STAT) begin
               n.sel[wi[2:0]] = merge10(r.sel[wi[2:0]], r.wd[9:0],
                                        lm[9:0]);
            end else if (wi == IX_STAT) begin
               clr_st = r.wd[9:0] & lm[9:0];
            end else begin
               n.imsk = merge10(r.imsk, r.wd[9:0],
                                lm[9:0]);
            end
         end else begin
            // Port words; set and clear touch only bits written as one
            unique case (wi)
               IX_OUT:  n.out[wp] = merge(r.out[wp], d,
                                          lm[NPIN-1:0]);
               IX_SET:  n.out[wp] = r.out[wp]
                                  | (d & lm[NPIN-1:0]);
               IX_CLR:  n.out[wp] = r.out[wp]
                                  & ~(d & lm[NPIN-1:0]);
               IX_DIR:  n.dir[wp] = merge(r.dir[wp], d,
                                          lm[NPIN-1:0]);
               IX_MSK:  n.msk[wp] = merge(r.msk[wp], d, lm[NPIN-1:0]);
               IX_MPIN: n.out[wp] = merge(r.out[wp], d,
                                  lm[NPIN-1:0] & ~r.msk[wp]);
               IX_IEN:  n.ien[wp] = merge(r.ien[wp], d, lm[NPIN-1:0]);
               IX_PUEN: n.puen[wp] = merge(r.puen[wp], d, lm[NPIN-1:0]);
               IX_FSEL: n.fsel[wp] = merge(r.fsel[wp], d,
                                           lm[NPIN-1:0]);
               IX_GA:   n.ga[wp] = merge(r.ga[wp], d,
                                         lm[NPIN-1:0]);
               IX_GB:   n.gb[wp] = merge(r.gb[wp], d,
                                         lm[NPIN-1:0]);
               default: n.bresp = RESP_OKAY;                // Pin is read only
            endcase
         end
      end

      // Read channel answers one cycle after the address
      // Only one answer stands; the next address waits for rready
      if (r.rvalid && s_axi_rready) begin
         n.rvalid = 1'b0;
      end
      if (s_axi_arvalid && r.arready) begin
         n.rvalid = 1'b1;
         n.rdata  = rd(r, live, s_axi_araddr);
         n.rresp  = mapped(s_axi_araddr) ? RESP_OKAY : RESP_DECERR;
      end

      // Pin interrupt sources
      set_st = 10'h0;
      for (int k = 0; k < NSRC; k++) begin
         sv = src_level(live, r.sel[k]);
         set_st[k] = r.sel[k][SEL_LEVEL] ? sv
                                          : sv & ~r.prev[k];
         n.prev[k] = sv;
      end

      // Group interrupts when the first enabled pin goes high while all enabled pins were low
      gcond_a       = |(live & r.ga);
      gcond_b       = |(live & r.gb);
      set_st[ST_GA] = gcond_a & ~r.ga_prev;
      set_st[ST_GB] = gcond_b & ~r.gb_prev;
      n.ga_prev     = gcond_a;
      n.gb_prev     = gcond_b;

      // Sticky status: a set wins over a clear in the same cycle
      n.stat = (r.stat & ~clr_st) | set_st;

      // Interrupt lines register the masked status
      n.irq  = |(n.stat & n.imsk);
      n.gia  = n.stat[ST_GA] & n.imsk[ST_GA];
      n.gib  = n.stat[ST_GB] & n.imsk[ST_GB];

      // Ready flags and pad drive from the next state
      n.awready = !n.awv;
      n.wready  = !n.wv;
      n.arready = !n.rvalid;
      n.pad.out = n.out;
      n.pad.oe  = n.dir & ~n.fsel;
      n.pad.pu  = n.puen;
      n.pad.ie  = n.ien;
   end

   // State register; reset makes every pin an input with pull-up
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         r           <= '0;
         r.puen      <= {NPORT{RST_PU}};
         r.pad.pu    <= {NPORT{RST_PU}};
         // Sources idle high after reset, so no false edge follows
         r.prev      <= '1;
         r.awready   <= 1'b1;
         r.wready    <= 1'b1;
         r.arready   <= 1'b1;
      end else begin
         r <= n;
      end
   end

   // Outputs straight from the state flops
   assign s_axi_awready   = r.awready;
   assign s_axi_wready    = r.wready;
   assign s_axi_bvalid    = r.bvalid;
   assign s_axi_bresp     = r.bresp;
   assign s_axi_arready   = r.arready;
   assign s_axi_rvalid    = r.rvalid;
   assign s_axi_rdata     = r.rdata;
   assign s_axi_rresp     = r.rresp;
   assign pad             = r.pad;
   assign irq             = r.irq;
   assign pin_group_irq_a = r.gia;
   assign pin_group_irq_b = r.gib;

endmodule : gpiop_top
`default_nettype wire

/* pkg/gpiop_pkg.sv */
// Constants, field layouts and carrier types of the GPIO port block
`default_nettype none
package gpiop_pkg;
   // Geometry
   localparam int NPORT = 8;
   localparam int NPIN  = 31;
   localparam int NSRC  = 8;
   localparam int AW    = 12;

   // Per-port register word index, port block at port * 16#40
   localparam logic [3:0] IX_OUT  = 4'h0;  // Output latch
   localparam logic [3:0] IX_SET  = 4'h1;  // Write one to set
   localparam logic [3:0] IX_CLR  = 4'h2;  // Write one to clear
   localparam logic [3:0] IX_DIR  = 4'h3;  // 1 = output
   localparam logic [3:0] IX_MSK  = 4'h4;  // 1 = masked in masked view
   localparam logic [3:0] IX_PIN  = 4'h5;  // Live pin level
   localparam logic [3:0] IX_MPIN = 4'h6;  // Masked port view
   localparam logic [3:0] IX_IEN  = 4'h7;  // Input receiver enable
   localparam logic [3:0] IX_PUEN = 4'h8;  // Pull-up enable
   localparam logic [3:0] IX_FSEL = 4'h9;  // pin_function_select, 1 = other
   localparam logic [3:0] IX_GA   = 4'ha;  // Group A pin enables
   localparam logic [3:0] IX_GB   = 4'hb;  // Group B pin enables
   localparam logic [3:0] IX_PMAX = 4'hb;

   // Global words, at 16#200 + 4 * index
   localparam logic [3:0] IX_STAT = 4'h8;  // Sticky status, write 1 clears
   localparam logic [3:0] IX_IMSK = 4'h9;  // Interrupt mask
   localparam logic [3:0] IX_GMAX = 4'h9;

   // Source select fields and group status bits
   localparam int SEL_PIN_LSB  = 0;
   localparam int SEL_PORT_LSB = 5;
   localparam int SEL_LEVEL    = 8;
   localparam int SEL_POL      = 9;
   localparam int ST_GA        = 8;
   localparam int ST_GB        = 9;

   // Reset values and bus answers
   localparam logic [NPIN-1:0] RST_PU = 31'h7fffffff;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   typedef logic [NPORT-1:0][NPIN-1:0] gpiop_bank_t;

   // Pad carrier
   typedef struct packed {
      gpiop_bank_t out;
      gpiop_bank_t oe;
      gpiop_bank_t pu;
      gpiop_bank_t ie;
   } gpiop_pad_t;

   // Whole state of the block
   typedef struct packed {
      logic            awready;
      logic            wready;
      logic            arready;
      logic            awv;
      logic            wv;
      logic [AW-1:0]   awa;
      logic [31:0]     wd;
      logic [3:0]      ws;
      logic            bvalid;
      logic [1:0]      bresp;
      logic            rvalid;
      logic [1:0]      rresp;
      logic [31:0]     rdata;
      gpiop_bank_t     out;
      gpiop_bank_t     dir;
      gpiop_bank_t     msk;
      gpiop_bank_t     ien;
      gpiop_bank_t     puen;
      gpiop_bank_t     fsel;
      gpiop_bank_t     ga;
      gpiop_bank_t     gb;
      gpiop_bank_t     sync1;
      gpiop_bank_t     sync2;
      logic [NSRC-1:0][9:0] sel;
      logic [NSRC-1:0] prev;
      logic            ga_prev;
      logic            gb_prev;
      logic [9:0]      stat;
      logic [9:0]      imsk;
      logic            irq;
      logic            gia;
      logic            gib;
      gpiop_pad_t      pad;
   } gpiop_state_t;
endpackage : gpiop_pkg
`default_nettype wire

/* tb/gpiop_sva.sv */
// Bus and pad timing checker for the GPIO port block
`timescale 1ns/1ps
`default_nettype none
module gpiop_sva
   import gpiop_pkg::*;
(
   // Clock and reset
   input wire logic        clk,
   input wire logic        resetn,
   // Register bus
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   // Pads and interrupts
   input wire gpiop_pad_t  pad,
   input wire logic        irq,
   input wire logic        pin_group_irq_a,
   input wire logic        pin_group_irq_b
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   // Pads, bus answers and interrupt outputs
   a_pad_reset: assert property (
      $rose(resetn) |-> pad.oe == '0 && pad.ie == '0 && pad.pu == '1)
      else $error("pads not idle after reset");
   a_wr_answer: assert property (
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> !s_axi_awready ##1 s_axi_bvalid)
      else $error("write answer late");
   a_rd_answer: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("read answer late");
   a_rd_hold: assert property (
      s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   a_ar_block: assert property (
      s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while answer pending");
   a_bresp_code: assert property (
      s_axi_bvalid |-> s_axi_bresp == RESP_OKAY || s_axi_bresp == RESP_DECERR)
      else $error("bad write response code");
   a_pad_cause: assert property (
      $changed(pad.out) || $changed(pad.oe)
      |-> s_axi_bvalid || $past(s_axi_bvalid))
      else $error("pad output moved without a write");
   a_grp_irq: assert property (
      pin_group_irq_a || pin_group_irq_b |-> irq)
      else $error("group interrupt without summary interrupt");

   // Main scenarios
   c_write: cover property (s_axi_awvalid && s_axi_awready ##2 s_axi_bvalid);
   c_read: cover property (s_axi_rvalid && !s_axi_rready);
   c_irq: cover property ($rose(irq));
   c_grp: cover property ($rose(pin_group_irq_a));
endmodule : gpiop_sva
`default_nettype wire

/* tb/gpiop_board.sv */
// Board model: external drivers and pull-ups on the port pins
`timescale 1ns/1ps
`default_nettype none
module gpiop_board
   import gpiop_pkg::*;
(
   // Clock
   input  wire logic        clk,
   // Block pads and board drivers
   input  wire gpiop_pad_t  pad,
   input  wire gpiop_bank_t ext_en,
   input  wire gpiop_bank_t ext_val,
   // Levels seen by the block
   output var  gpiop_bank_t pad_in
);
   gpiop_bank_t tog = '0;

   // Floating pins without pull-up wander every cycle
   always_ff @(posedge clk) tog <= ~tog;

   // Block drives where enabled, else the board, else pull-up or noise
   always_comb begin
      pad_in = (pad.oe & pad.out) | (~pad.oe & ext_en & ext_val)
             | (~pad.oe & ~ext_en & (pad.pu | tog));
   end
endmodule : gpiop_board
`default_nettype wire

/* tb/testbench.sv */
// Self-checking bench for the GPIO port block
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import gpiop_pkg::*;
   logic          clk = 1'b0, resetn = 1'b0, s_axi_bready = 1'b1;
   logic          s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic          s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic          s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic          s_axi_arready, s_axi_rvalid;
   logic [AW-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0]   s_axi_wdata = '0, s_axi_rdata;
   logic [3:0]    s_axi_wstrb = '0;
   logic [1:0]    s_axi_bresp, s_axi_rresp;
   gpiop_bank_t   pad_in, ext_en = '0, ext_val = '0;
   gpiop_pad_t    pad;
   logic          irq, pin_group_irq_a, pin_group_irq_b;
   int            n_fail = 0, checked = 0;

   gpiop_top gpiop_top_inst (.*);
   gpiop_board gpiop_board_inst (.*);

   // 200 MHz clock
   initial forever #2.5 clk = ~clk;

   task automatic complete_run;
      if (n_fail == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : complete_run

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: %h vs %h", $time, seen, exp);
      end
   endtask : chk

   task automatic tmo(input int n);
      if (n >= 200) begin
         n_fail++;
         complete_run();
      end
   endtask : tmo

   function automatic logic [11:0] pa(input int p, input logic [3:0] ix);
      return 12'(p * 64) + {6'h0, ix, 2'h0};
   endfunction : pa

   function automatic logic [11:0] ga(input logic [3:0] ix);
      return 12'h200 + {6'h0, ix, 2'h0};
   endfunction : ga

   // Write with address and data offered together, bready held high
   task automatic wr(input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s = 4'hf, input logic [1:0] e = 2'h0);
      int n = 0;
      logic aw = 1'b1, w = 1'b1;
      s_axi_awvalid <= 1'b1;
      s_axi_awaddr <= a;
      s_axi_wvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      do begin
         @(posedge clk);
         n++;
         if (aw && s_axi_awready) begin
            aw = 1'b0;
            s_axi_awvalid <= 1'b0;
         end
         if (w && s_axi_wready) begin
            w = 1'b0;
            s_axi_wvalid <= 1'b0;
         end
      end while (!s_axi_bvalid && n < 200);
      tmo(n);
      chk({30'h0, s_axi_bresp}, {30'h0, e});
   endtask : wr

   // Read; rready raised late so the answer has to stand
   task automatic rd(input logic [11:0] a, input logic [31:0] x,
                     input logic [1:0] e = 2'h0);
      int n = 0;
      s_axi_arvalid <= 1'b1;
      s_axi_araddr <= a;
      do begin
         @(posedge clk);
         n++;
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
      end while (!(s_axi_rvalid && s_axi_rready) && n < 200);
      s_axi_rready <= 1'b0;
      tmo(n);
      chk(s_axi_rdata, x);
      chk({30'h0, s_axi_rresp}, {30'h0, e});
   endtask : rd

   // Board drives port 3, then the synchroniser and status settle
   task automatic pins(input logic [30:0] v);
      ext_val[3] <= v;
      repeat (4) @(posedge clk);
   endtask : pins

   // Main sequence
   initial begin
      repeat (16) @(posedge clk);
      resetn <= 1'b1;
      ext_en[3] <= '1;
      @(posedge clk);
      chk({1'b0, pad.oe[2]}, 32'h0);
      chk({1'b0, pad.pu[5]}, 32'h7fffffff);
      chk({1'b0, pad.ie[0]}, 32'h0);
      rd(pa(0, IX_PUEN), 32'h7fffffff);
      rd(pa(4, IX_DIR), 32'h0);
      wr(pa(7, IX_OUT), 32'hffffffff);
      rd(pa(7, IX_OUT), 32'h7fffffff);
      wr(pa(2, IX_OUT), 32'h12345678);
      wr(pa(2, IX_SET), 32'h0000f00f);
      wr(pa(2, IX_CLR), 32'h12000001);
      rd(pa(2, IX_OUT), 32'h0034f67e);
      wr(pa(2, IX_OUT), 32'h00aa0000, 4'h4);
      rd(pa(2, IX_OUT), 32'h00aaf67e);
      wr(pa(2, IX_DIR), 32'h0000ffff);
      wr(pa(2, IX_FSEL), 32'h00000001);
      @(posedge clk);
      chk({1'b0, pad.oe[2]}, 32'h0000fffe);
      chk({1'b0, pad.out[2]}, 32'h00aaf67e);
      wr(pa(2, IX_MSK), 32'h0000ffff);
      wr(pa(2, IX_MPIN), 32'h55555555);
      rd(pa(2, IX_OUT), 32'h5555f67e);
      ext_val[3] <= 31'h12345;
      rd(pa(3, IX_PIN), 32'h0);
      wr(pa(3, IX_IEN), 32'h0000ffff);
      chk({1'b0, pad.ie[3]}, 32'h0000ffff);
      rd(pa(3, IX_PIN), 32'h00002345);
      wr(pa(3, IX_MSK), 32'h0000000f);
      rd(pa(3, IX_MPIN), 32'h00002340);
      pins(31'h0);
      wr(ga(4'h0), 32'h00000260);
      wr(ga(4'h1), 32'h00000361);
      wr(pa(3, IX_GA), 32'h00000004);
      wr(ga(IX_IMSK), 32'h00000103);
      wr(ga(IX_STAT), 32'h000003ff);
      chk({31'h0, irq}, 32'h0);
      pins(31'h7);
      chk({29'h0, pin_group_irq_a, pin_group_irq_b, irq}, 32'h5);
      rd(ga(IX_STAT), 32'h00000103);
      wr(ga(IX_STAT), 32'h00000003);
      rd(ga(IX_STAT), 32'h00000102);
      wr(ga(IX_IMSK), 32'h00000000);
      @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      pins(31'h0);
      wr(ga(IX_STAT), 32'h000003ff);
      rd(ga(IX_STAT), 32'h0);
      // Falling edge source on pin 3 and group B on the same pin
      wr(ga(4'h2), 32'h00000063);
      wr(pa(3, IX_GB), 32'h00000008);
      wr(ga(IX_IMSK), 32'h00000200);
      pins(31'h8);
      chk({29'h0, pin_group_irq_a, pin_group_irq_b, irq}, 32'h3);
      pins(31'h0);
      rd(ga(IX_STAT), 32'h00000204);
      rd(12'h300, 32'h0, RESP_DECERR);
      wr(12'h300, 32'h1, 4'hf, RESP_DECERR);
      complete_run();
   end
endmodule : testbench

bind gpiop_top gpiop_sva gpiop_sva_inst (.*);
`default_nettype wire
